// *** shared/wds_pkg.sv ***
// Constants, register map and carrier types for the watchdog and supply block.
// Assumes a 50 MHz system clock and a 32-bit AHB-Lite register bus.
package wds_pkg;

    // ****************************************
    // Register map (word index, byte = 4*index)
    // ****************************************
    localparam int WDS_ADDR_W = 8;
    localparam logic [5:0] WDS_IDX_WDT_CTRL = 6'h31;  // watchdog_control
    localparam logic [5:0] WDS_IDX_SUPPLY = 6'h34;    // supply_monitor_control_status
    localparam logic [5:0] WDS_IDX_RST_FLAGS = 6'h3B; // reset_cause_flags
    localparam logic [5:0] WDS_IDX_PROTECT = 6'h3C;   // change_protection_register

    // ****************************************
    // Field positions
    // ****************************************
    localparam int WDS_BIT_WDT_FLAG = 7;
    localparam int WDS_BIT_WDT_IE = 6;
    localparam int WDS_BIT_WDP3 = 5;
    localparam int WDS_BIT_WDE = 3;
    localparam int WDS_BIT_SM_FLAG = 7;
    localparam int WDS_BIT_SM_IE = 6;
    localparam int WDS_BIT_RF_WD = 3;
    localparam int WDS_BIT_RF_EXT = 1;
    localparam int WDS_BIT_RF_POR = 0;

    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [7:0] WDS_CTRL_RESET = 8'h00;
    localparam logic [7:0] WDS_PROT_SIGNATURE = 8'hD8;
    localparam logic [2:0] WDS_PROT_WINDOW_CYCLES = 3'h4;
    localparam int WDS_CNT_W = 20;
    localparam logic [20:0] WDS_BASE_CYCLES = 21'h000800;
    localparam logic [3:0] WDS_MAX_CODE = 4'h9;
    localparam int WDS_OSC_HZ = 128000;

    // Supply trigger level codes
    localparam logic [2:0] WDS_LVL_OFF = 3'h0;
    localparam logic [2:0] WDS_LVL_POR_LO = 3'h1;
    localparam logic [2:0] WDS_LVL_POR_HI = 3'h2;
    localparam logic [2:0] WDS_LVL_IRQ_LO = 3'h3;
    localparam logic [2:0] WDS_LVL_IRQ_HI = 3'h4;

    localparam logic [1:0] WDS_HTRANS_NONSEQ = 2'h2;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        WDS_MODE_STOPPED = 4'b0001,
        WDS_MODE_IRQ = 4'b0010,
        WDS_MODE_RESET = 4'b0100,
        WDS_MODE_IRQ_RESET = 4'b1000
    } wds_mode_t;

    typedef struct packed {
        logic hsel;
        logic [WDS_ADDR_W-1:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } wds_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } wds_ahb_rsp_t;

    typedef struct packed {
        logic restart;       // Watchdog restart instruction, one cycle
        logic irq_global_en; // Global interrupt enable of core_status_register
        logic vector_ack;    // Core executes the watchdog vector, one cycle
    } wds_core_t;

endpackage : wds_pkg

// *** src/wds_counter.sv ***
// Watchdog time-out counter, advanced by oscillator ticks.
// Assumes tick is a one-cycle pulse already synchronised to clk.
module wds_counter
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic tick,
    input wire logic restart,
    input wire logic [3:0] code,
    output logic timeout
);
    import wds_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [WDS_CNT_W-1:0] cnt; // Oscillator cycles counted
        logic timeout;             // One-cycle time-out pulse
    } wds_cnt_state_t;

    wds_cnt_state_t st;
    wds_cnt_state_t next_st;
    logic [3:0] eff_code;
    logic [20:0] period;

    // Reserved codes run at the longest period rather than wrap silently
    always_comb
    begin
        eff_code = (code > WDS_MAX_CODE) ? WDS_MAX_CODE : code;
        period = WDS_BASE_CYCLES << eff_code;
    end

    // Count ticks, fire and restart at the selected period
    always_comb
    begin
        next_st = st;
        next_st.timeout = 1'b0;
        if (restart)
        begin
            next_st.cnt = '0;
        end
        else if (tick)
        begin
            // Last tick of the period
            if ({1'b0, st.cnt} == period - 21'h000001)
            begin
                next_st.cnt = '0;
                next_st.timeout = 1'b1;
            end
            else
            begin
                next_st.cnt = st.cnt + 20'h00001;
            end
        end
    end

    // Register the state; clock enable freezes it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign timeout = st.timeout;

    // ****************************************
    // Checks
    // ****************************************
    property p_restart_zero;
        @(posedge clk) disable iff (rst)
        (ce && restart) |=> (st.cnt == '0 && !st.timeout);
    endproperty
    a_restart_zero: assert property (p_restart_zero)
        else $error("counter not cleared by restart");

    property p_timeout_cause;
        @(posedge clk) disable iff (rst)
        $rose(st.timeout) |-> ($past(tick) && $past(st.cnt) == 20'(period - 21'h000001));
    endproperty
    a_timeout_cause: assert property (p_timeout_cause)
        else $error("time-out without full period");

endmodule : wds_counter

// *** src/wds_top.sv ***
// Watchdog, supply-level monitor control and reset-cause flags behind AHB-Lite.
// Assumes pin inputs are asynchronous; core strobes share CLK.
//
// Function
// - Time-out in interrupt mode sets watchdog flag
// - Flag cleared by vector or writing one
// - Interrupt needs global and watchdog enables set
// - Reset and interrupt enables select the mode
// - Programmed lock fuse forces system reset mode
// - Combined mode vector clears enable and flag
// - Unserviced combined-mode interrupt then resets on time-out
// - Reset enable forced while watchdog cause set
// - Prescale code doubles period from 2048 cycles
// - Supply flag set on trigger, cleared when supply high or level off
// - Supply interrupt whenever flag set and enabled
// - Levels one and two give power-on reset
// - Levels three and four set supply flag
// - Watchdog cause set by watchdog reset
// - External cause set by external reset
// - Power-on cause cleared only by software
// - Counter runs from separate slow oscillator
// - Counter restarts on instruction, disable, reset
// - Watchdog reset pulse lasts one clock
// - Protected signature opens four-cycle change window
module wds_top
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wds_pkg::wds_ahb_req_t AHB_REQ,
    output wds_pkg::wds_ahb_rsp_t AHB_RSP,
    input wds_pkg::wds_core_t CORE,
    input wire logic OSC_SLOW,
    input wire logic LOCK_FUSE_UNPROG,
    input wire logic EXT_RESET,
    input wire logic SUPPLY_LOW,
    output logic WDT_IRQ,
    output logic SUPPLY_IRQ,
    output logic WDT_SYS_RESET,
    output logic SUPPLY_POR_REQ,
    output logic [2:0] SUPPLY_LEVEL_SEL
);
    import wds_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic osc_s1, osc_s2, osc_prev; // Slow oscillator synchroniser
        logic fuse_s1, fuse_s2;         // Lock fuse synchroniser
        logic ext_s1, ext_s2;           // External reset synchroniser
        logic low_s1, low_s2;           // Supply comparator synchroniser
        logic wdt_flag, wdt_ie, watchdog_reset_enable;    // Watchdog control bits
        logic [3:0] wdp;                // Prescale select
        logic sm_flag, sm_ie;           // Supply monitor bits
        logic [2:0] sm_level;           // Trigger level
        logic rf_wd, rf_ext, rf_por;    // Reset causes
        logic [2:0] prot_cnt;           // Protected change window
        logic wr_pend, rd_pend;         // Bus data phase pending
        logic [5:0] bus_idx;            // Latched register index
        wds_ahb_rsp_t rsp;              // Bus answer
        logic wdt_irq, sm_irq, sys_reset, por_req;
    } wds_state_t;

    wds_state_t s;
    wds_state_t next_s;
    logic timeout;       // Counter time-out pulse
    logic osc_tick;      // Rising edge of slow oscillator
    logic cnt_restart;   // Counter restart request
    logic fuse_prog;     // Lock fuse programmed
    logic wde_eff;       // Reset enable as seen by logic and software
    logic prot_open;     // Protected change allowed now
    logic do_reset;      // Watchdog system reset this cycle
    logic dev_reset;     // Any device reset clearing control state
    wds_mode_t mode;     // Current watchdog mode
    logic [7:0] wd;      // Written byte
    logic [7:0] rdata;   // Byte selected for reading

    // ****************************************
    // Derived conditions
    // ****************************************
    always_comb
    begin
        osc_tick = s.osc_s2 && !s.osc_prev;
        fuse_prog = !s.fuse_s2;
        wde_eff = s.watchdog_reset_enable || s.rf_wd || fuse_prog;
        prot_open = (s.prot_cnt != 3'h0);
        wd = AHB_REQ.hwdata[7:0];
        // Mode from fuse and enables
        if (fuse_prog)
        begin
            mode = WDS_MODE_RESET;
        end
        else
        begin
            unique case ({wde_eff, s.wdt_ie})
                2'b00: mode = WDS_MODE_STOPPED;
                2'b01: mode = WDS_MODE_IRQ;
                2'b10: mode = WDS_MODE_RESET;
                2'b11: mode = WDS_MODE_IRQ_RESET;
            endcase
        end
        // Time-out action; unserviced combined interrupt escalates
        do_reset = 1'b0;
        if (timeout)
        begin
            unique case (mode)
                WDS_MODE_STOPPED: do_reset = 1'b0;
                WDS_MODE_IRQ: do_reset = 1'b0;
                WDS_MODE_RESET: do_reset = 1'b1;
                WDS_MODE_IRQ_RESET: do_reset = s.wdt_flag;
            endcase
        end
        dev_reset = s.sys_reset || s.ext_s2;
        cnt_restart = CORE.restart || (mode == WDS_MODE_STOPPED) || dev_reset;
    end

    // Read mux; reserved bits read as zero
    always_comb
    begin
        rdata = 8'h00;
        unique case (s.bus_idx)
            WDS_IDX_WDT_CTRL: rdata = {s.wdt_flag, s.wdt_ie, s.wdp[3], 1'b0,
                                       wde_eff, s.wdp[2:0]};
            WDS_IDX_SUPPLY: rdata = {s.sm_flag, s.sm_ie, 3'h0, s.sm_level};
            WDS_IDX_RST_FLAGS: rdata = {4'h0, s.rf_wd, 1'b0, s.rf_ext, s.rf_por};
            default: rdata = 8'h00;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        next_s = s;
        // Two flip-flops on every pin input
        next_s.osc_s1 = OSC_SLOW;
        next_s.osc_s2 = s.osc_s1;
        next_s.osc_prev = s.osc_s2;
        next_s.fuse_s1 = LOCK_FUSE_UNPROG;
        next_s.fuse_s2 = s.fuse_s1;
        next_s.ext_s1 = EXT_RESET;
        next_s.ext_s2 = s.ext_s1;
        next_s.low_s1 = SUPPLY_LOW;
        next_s.low_s2 = s.low_s1;

        // Protection window runs down
        if (prot_open)
        begin
            next_s.prot_cnt = s.prot_cnt - 3'h1;
        end

        // Bus: address phase taken, reads get one wait state
        next_s.rsp.hresp = 1'b0;
        next_s.wr_pend = 1'b0;
        next_s.rd_pend = 1'b0;
        if (s.rd_pend)
        begin
            next_s.rsp.hrdata = {24'h000000, rdata};
            next_s.rsp.hreadyout = 1'b1;
        end
        else if (AHB_REQ.hsel && AHB_REQ.htrans == WDS_HTRANS_NONSEQ && AHB_REQ.hready)
        begin
            next_s.bus_idx = AHB_REQ.haddr[7:2];
            next_s.wr_pend = AHB_REQ.hwrite;
            next_s.rd_pend = !AHB_REQ.hwrite;
            next_s.rsp.hreadyout = AHB_REQ.hwrite;
        end

        // Write data phase
        if (s.wr_pend)
        begin
            unique case (s.bus_idx)
                WDS_IDX_WDT_CTRL:
                begin
                    next_s.wdt_ie = wd[WDS_BIT_WDT_IE];
                    if (wd[WDS_BIT_WDT_FLAG])
                    begin
                        next_s.wdt_flag = 1'b0;
                    end
                    // Disabling needs the window; a set cause holds it on
                    next_s.watchdog_reset_enable = wd[WDS_BIT_WDE] || s.rf_wd || (s.watchdog_reset_enable && !prot_open);
                    // Under the fuse the period is protected too
                    if (!fuse_prog || prot_open)
                    begin
                        next_s.wdp = {wd[WDS_BIT_WDP3], wd[2:0]};
                    end
                    next_s.prot_cnt = 3'h0;
                end
                WDS_IDX_SUPPLY:
                begin
                    // Flag bit is read-only
                    next_s.sm_ie = wd[WDS_BIT_SM_IE];
                    next_s.sm_level = wd[2:0];
                    if (wd[2:0] == WDS_LVL_OFF)
                    begin
                        next_s.sm_flag = 1'b0;
                    end
                end
                WDS_IDX_RST_FLAGS:
                begin
                    // Writing zero clears, writing one leaves unchanged
                    next_s.rf_wd = s.rf_wd && wd[WDS_BIT_RF_WD];
                    next_s.rf_ext = s.rf_ext && wd[WDS_BIT_RF_EXT];
                    next_s.rf_por = s.rf_por && wd[WDS_BIT_RF_POR];
                end
                WDS_IDX_PROTECT:
                begin
                    if (wd == WDS_PROT_SIGNATURE)
                    begin
                        next_s.prot_cnt = WDS_PROT_WINDOW_CYCLES;
                    end
                end
                default:
                begin
                    // Unmapped: ignored, still OKAY
                end
            endcase
        end

        // Vector execution clears flag, and enable in combined mode
        if (CORE.vector_ack)
        begin
            next_s.wdt_flag = 1'b0;
            if (mode == WDS_MODE_IRQ_RESET)
            begin
                next_s.wdt_ie = 1'b0;
            end
        end

        // Hardware set wins over vector and write clears in the same cycle
        if (timeout && !do_reset && (mode == WDS_MODE_IRQ || mode == WDS_MODE_IRQ_RESET))
        begin
            next_s.wdt_flag = 1'b1;
        end

        // Supply monitor: flag tracks the low condition at flagging levels
        if (!s.low_s2 || s.sm_level == WDS_LVL_OFF)
        begin
            next_s.sm_flag = 1'b0;
        end
        if (s.low_s2 && (s.sm_level == WDS_LVL_IRQ_LO || s.sm_level == WDS_LVL_IRQ_HI))
        begin
            next_s.sm_flag = 1'b1;
        end
        // Reset levels request a power-on reset, flag untouched
        next_s.por_req = s.low_s2 &&
            (s.sm_level == WDS_LVL_POR_LO || s.sm_level == WDS_LVL_POR_HI);

        // Causes
        if (do_reset)
        begin
            next_s.rf_wd = 1'b1;
        end
        if (s.ext_s2)
        begin
            next_s.rf_ext = 1'b1;
        end

        // Device reset clears control state but keeps the causes
        if (dev_reset)
        begin
            {next_s.wdt_flag, next_s.wdt_ie, next_s.wdp[3], next_s.watchdog_reset_enable, next_s.wdp[2:0]} =
                {WDS_CTRL_RESET[7:5], WDS_CTRL_RESET[3:0]};
            next_s.watchdog_reset_enable = s.rf_wd;
            next_s.sm_flag = 1'b0;
            next_s.sm_ie = 1'b0;
            next_s.sm_level = WDS_LVL_OFF;
            next_s.prot_cnt = 3'h0;
        end

        // Outputs from flip-flops
        next_s.sys_reset = do_reset;
        next_s.wdt_irq = next_s.wdt_flag && next_s.wdt_ie && CORE.irq_global_en;
        next_s.sm_irq = next_s.sm_flag && next_s.sm_ie;
    end

    // Power-on reset: causes cleared except power-on, which sets
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            s <= '0;
            s.fuse_s1 <= 1'b1;
            s.fuse_s2 <= 1'b1;
            s.rf_por <= 1'b1;
            s.rsp.hreadyout <= 1'b1;
        end
        else if (CE)
        begin
            s <= next_s;
        end
    end

    // ****************************************
    // Counter
    // ****************************************
    wds_counter u_counter
    (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .tick(osc_tick),
        .restart(cnt_restart),
        .code(s.wdp),
        .timeout(timeout)
    );

    assign AHB_RSP = s.rsp;
    assign WDT_IRQ = s.wdt_irq;
    assign SUPPLY_IRQ = s.sm_irq;
    assign WDT_SYS_RESET = s.sys_reset;
    assign SUPPLY_POR_REQ = s.por_req;
    assign SUPPLY_LEVEL_SEL = s.sm_level;

    // ****************************************
    // Checks
    // ****************************************
    property p_flag_set;
        @(posedge CLK) disable iff (RST)
        (CE && timeout && mode == WDS_MODE_IRQ && !dev_reset) |=> s.wdt_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set on interrupt time-out");

    property p_vec_clear;
        @(posedge CLK) disable iff (RST)
        (CE && CORE.vector_ack && !timeout) |=> !s.wdt_flag;
    endproperty
    a_vec_clear: assert property (p_vec_clear)
        else $error("vector did not clear flag");

    property p_irq_gate;
        @(posedge CLK) disable iff (RST)
        s.wdt_irq |-> ($past(CORE.irq_global_en) && s.wdt_ie && s.wdt_flag);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without both enables");

    property p_stopped_quiet;
        @(posedge CLK) disable iff (RST)
        (mode == WDS_MODE_STOPPED && CE)[*2] |-> !timeout;
    endproperty
    a_stopped_quiet: assert property (p_stopped_quiet)
        else $error("time-out while stopped");

    property p_fuse_reset;
        @(posedge CLK) disable iff (RST)
        (CE && timeout && fuse_prog) |=> (s.sys_reset && s.rf_wd);
    endproperty
    a_fuse_reset: assert property (p_fuse_reset)
        else $error("no reset on time-out under fuse");

    property p_combined_vec;
        @(posedge CLK) disable iff (RST)
        (CE && CORE.vector_ack && mode == WDS_MODE_IRQ_RESET && !timeout)
            |=> (!s.wdt_ie && !s.wdt_flag);
    endproperty
    a_combined_vec: assert property (p_combined_vec)
        else $error("combined vector left enable set");

    property p_escalate;
        @(posedge CLK) disable iff (RST)
        (CE && timeout && mode == WDS_MODE_IRQ_RESET && s.wdt_flag) |=> s.sys_reset;
    endproperty
    a_escalate: assert property (p_escalate)
        else $error("unserviced interrupt did not reset");

    property p_wde_forced;
        @(posedge CLK) disable iff (RST)
        (s.rf_wd && CE) |=> s.watchdog_reset_enable;
    endproperty
    a_wde_forced: assert property (p_wde_forced)
        else $error("reset enable cleared while cause set");

    property p_pulse;
        @(posedge CLK) disable iff (RST)
        (s.sys_reset && CE) |=> !s.sys_reset;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("watchdog reset longer than one cycle");

    property p_sm_clear;
        @(posedge CLK) disable iff (RST)
        (CE && !s.low_s2) |=> !s.sm_flag;
    endproperty
    a_sm_clear: assert property (p_sm_clear)
        else $error("supply flag held with supply high");

endmodule : wds_top

// *** sim/wds_core_model.sv ***
// Core model: global enable, restart instruction and watchdog vector execution.
// Assumes one shared clock with the block; strobes are one-cycle pulses.
module wds_core_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic irq,
    input wire logic ack_en,
    input wire logic gie,
    input wire logic kick,
    input wire logic [2:0] dly,
    output wds_pkg::wds_core_t core
);
    timeunit 1ns;
    timeprecision 1ps;
    import wds_pkg::*;
    logic [2:0] cnt; // Service latency so far
    logic done; // One vector per request
    // Vector taken after dly cycles; enable is never re-set here
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            core <= '0;
            cnt <= 3'h0;
            done <= 1'b0;
        end
        else
        begin
            core.irq_global_en <= gie;
            core.restart <= kick;
            core.vector_ack <= 1'b0;
            if (!irq)
            begin
                cnt <= 3'h0;
                done <= 1'b0;
            end
            else if (ack_en && !done && cnt == dly)
            begin
                core.vector_ack <= 1'b1;
                done <= 1'b1;
            end
            else if (ack_en && !done)
                cnt <= cnt + 3'h1;
        end
    end
endmodule : wds_core_model

// *** sim/wds_top_test.sv ***
// Self-checking bench for wds_top: AHB-Lite master, core model, slow oscillator.
// Assumes wds_pkg and the core model are compiled first; 50 MHz clock.
module wds_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import wds_pkg::*;
    localparam logic [7:0] A_CTL = {WDS_IDX_WDT_CTRL, 2'b00};
    localparam logic [7:0] A_SUP = {WDS_IDX_SUPPLY, 2'b00};
    localparam logic [7:0] A_FLG = {WDS_IDX_RST_FLAGS, 2'b00};
    localparam logic [7:0] A_PRT = {WDS_IDX_PROTECT, 2'b00};
    logic clk = 0, rst = 1, ce = 1, osc = 0, lock = 1, ext_rst = 0, sup_low = 0;
    logic sel = 0, wr = 0, gie = 0, ack_en = 0, kick = 0;
    logic [1:0] trans = 2'h0, osc_div = 2'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, q, v;
    logic wdt_irq, sup_irq, sys_rst, por_req;
    logic [2:0] lvl_sel;
    wds_ahb_req_t req;
    wds_ahb_rsp_t rsp;
    wds_core_t core;
    int n_mismatch = 0, n_checks = 0, cyc = 0, n_tick = 0, t0, d;
    // hready is the slave's own hreadyout
    always_comb req = '{sel, addr, trans, wr, 3'h2, {24'h0, wdata}, rsp.hreadyout};
    initial
    begin
        forever #10 clk = ~clk;
    end
    // Free-running slow oscillator, 4 clocks a period, and the hang limit
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        osc_div <= osc_div + 2'h1;
        osc <= osc_div[1];
        if (osc_div == 2'h1)
            n_tick <= n_tick + 1;
        if (cyc == 60000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    wds_core_model u_core (.clk(clk), .rst(rst), .irq(wdt_irq), .ack_en(ack_en), .gie(gie),
        .kick(kick), .dly(3'h5), .core(core));
    wds_top DUT (.CLK(clk), .RST(rst), .CE(ce), .AHB_REQ(req), .AHB_RSP(rsp), .CORE(core),
        .OSC_SLOW(osc), .LOCK_FUSE_UNPROG(lock), .EXT_RESET(ext_rst), .SUPPLY_LOW(sup_low),
        .WDT_IRQ(wdt_irq), .SUPPLY_IRQ(sup_irq), .WDT_SYS_RESET(sys_rst),
        .SUPPLY_POR_REQ(por_req), .SUPPLY_LEVEL_SEL(lvl_sel));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic int period(input logic [3:0] code);
        return int'(WDS_BASE_CYCLES) << code;
    endfunction : period
    // Supply register image: flag only for the interrupt levels
    function automatic logic [7:0] sup_exp(input int l, input logic low);
        return {low && l > 2, 1'b1, 3'h0, 3'(l)};
    endfunction : sup_exp
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One single word transfer; entered just after a clock edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] dat);
        sel <= 1'b1;
        addr <= a;
        trans <= WDS_HTRANS_NONSEQ;
        wr <= w;
        do @(posedge clk); while (rsp.hreadyout !== 1'b1);
        trans <= 2'h0;
        sel <= 1'b0;
        wdata <= dat;
        do @(posedge clk); while (rsp.hreadyout !== 1'b1);
        q = rsp.hrdata[7:0];
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        bus(1'b0, a, 8'h00);
        chk(nm, e, q);
        chk("hresp", 8'h00, {7'h0, rsp.hresp});
    endtask : rd
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'h8686C0AA));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(A_CTL, 8'h00, "ctrl");
        rd(A_SUP, 8'h00, "supply");
        rd(A_FLG, 8'h01, "flags");
        rd(8'h40, 8'h00, "unmapped");
        bus(1'b1, A_FLG, 8'h00);
        rd(A_FLG, 8'h00, "flags");
        ext_rst <= 1'b1;
        repeat (6) @(posedge clk);
        ext_rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd(A_FLG, 8'h02, "flags");
        bus(1'b1, A_FLG, 8'h00);
        rd(A_FLG, 8'h00, "flags");
        // Random images: flag bit and reserved bits never stick
        repeat (4)
        begin
            v = 8'($urandom);
            bus(1'b1, A_SUP, v);
            rd(A_SUP, v & 8'h47, "supply");
        end
        // Clock enable low: a low supply must not be seen at all
        bus(1'b1, A_SUP, 8'h43);
        ce <= 1'b0;
        sup_low <= 1'b1;
        repeat (6) @(posedge clk);
        chk("sup_irq", 8'h00, {7'h0, sup_irq});
        ce <= 1'b1;
        sup_low <= 1'b0;
        repeat (4) @(posedge clk);
        for (int l = 1; l <= 4; l++)
        begin
            bus(1'b1, A_SUP, 8'h40 | 8'(l));
            sup_low <= 1'b1;
            repeat (4) @(posedge clk);
            chk("level", 8'(l), {5'h0, lvl_sel});
            chk("sup_irq", {7'h0, l > 2}, {7'h0, sup_irq});
            chk("por_req", {7'h0, l < 3}, {7'h0, por_req});
            rd(A_SUP, sup_exp(l, 1'b1), "supply");
            sup_low <= 1'b0;
            repeat (4) @(posedge clk);
            rd(A_SUP, sup_exp(l, 1'b0), "supply");
        end
        bus(1'b1, A_SUP, 8'h00);
        // Interrupt mode, period counted from a restart
        gie <= 1'b1;
        bus(1'b1, A_CTL, 8'h40);
        repeat (1000) @(posedge clk);
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        t0 = n_tick;
        wait (wdt_irq === 1'b1);
        d = n_tick - t0;
        chk("period", 8'h01, {7'h0, d >= period(0) - 1 && d <= period(0) + 3});
        @(posedge clk);
        rd(A_CTL, 8'hC0, "ctrl");
        gie <= 1'b0;
        repeat (5) @(posedge clk);
        chk("wdt_irq", 8'h00, {7'h0, wdt_irq});
        gie <= 1'b1;
        repeat (5) @(posedge clk);
        chk("wdt_irq", 8'h01, {7'h0, wdt_irq});
        bus(1'b1, A_CTL, 8'hC0);
        rd(A_CTL, 8'h40, "ctrl");
        bus(1'b1, A_CTL, 8'h00);
        // Combined mode, serviced, then a protected disable
        ack_en <= 1'b1;
        bus(1'b1, A_CTL, 8'h48);
        wait (wdt_irq === 1'b1);
        wait (wdt_irq === 1'b0);
        @(posedge clk);
        rd(A_CTL, 8'h08, "ctrl");
        bus(1'b1, A_PRT, WDS_PROT_SIGNATURE);
        bus(1'b1, A_CTL, 8'h00);
        rd(A_CTL, 8'h00, "ctrl");
        // Combined mode left unserviced: second time-out resets
        ack_en <= 1'b0;
        bus(1'b1, A_CTL, 8'h48);
        wait (wdt_irq === 1'b1);
        wait (sys_rst === 1'b1);
        @(posedge clk);
        #1 chk("sys_rst", 8'h00, {7'h0, sys_rst});
        repeat (3) @(posedge clk);
        rd(A_FLG, 8'h08, "flags");
        rd(A_CTL, 8'h08, "ctrl");
        bus(1'b1, A_PRT, WDS_PROT_SIGNATURE);
        bus(1'b1, A_CTL, 8'h00);
        rd(A_CTL, 8'h08, "ctrl");
        bus(1'b1, A_FLG, 8'h00);
        bus(1'b1, A_PRT, WDS_PROT_SIGNATURE);
        bus(1'b1, A_CTL, 8'h00);
        rd(A_CTL, 8'h00, "ctrl");
        lock <= 1'b0;
        repeat (4) @(posedge clk);
        rd(A_CTL, 8'h08, "ctrl");
        bus(1'b1, A_CTL, 8'h21);
        rd(A_CTL, 8'h08, "ctrl");
        wait (sys_rst === 1'b1);
        repeat (3) @(posedge clk);
        rd(A_FLG, 8'h08, "flags");
        bus(1'b1, A_PRT, WDS_PROT_SIGNATURE);
        bus(1'b1, A_CTL, 8'h21);
        rd(A_CTL, 8'h29, "ctrl");
        close_out();
    end
endmodule : wds_top_test
